// ### src/edf_desc_top.sv
// Descriptor field handling for an ethernet MAC DMA engine
`timescale 1ns/1ps
`include "edf_consts.svh"
module edf_desc_top #(
  parameter int FIFO_DEPTH = `EDF_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  // Receive descriptor side
  input wire logic rx_desc_load,
  input wire edf_pkg::edf_word_t rx_desc_word1,
  input wire edf_pkg::edf_word_t rx_desc_word2,
  input wire edf_pkg::edf_word_t rx_desc_word3,
  input wire logic rx_use_buf2,
  input wire logic rx_first_part,
  output logic [31:0] rx_wr_addr,
  output logic [2:0] rx_byte_shift,
  output logic [31:0] rx_next_desc,
  output logic rx_chain_mode,
  output logic rx_next_valid,
  // Transmit descriptor side
  input wire logic tx_desc_load,
  input wire edf_pkg::edf_word_t tx_desc_word0,
  input wire logic [12:0] tx_buf1_count,
  input wire logic [12:0] tx_buf2_count,
  input wire logic [31:0] tx_buf1_ptr,
  input wire logic [31:0] tx_buf2_ptr,
  input wire logic tx_byte_taken,
  input wire logic tx_frame_done,
  input wire logic tx_store_forward,
  input wire logic tx_fifo_full,
  input wire logic tx_sum_ready,
  input wire logic tx_payload_short,
  input wire logic ip_header_fault,
  input wire logic jabber_expired,
  input wire logic flush_cmd,
  input wire logic carrier_sense,
  input wire logic loss_of_carrier,
  input wire logic late_collision,
  input wire logic excess_collision,
  input wire logic excess_deferral,
  input wire logic underflow,
  output logic tx_desc_busy,
  output logic [31:0] tx_rd_addr,
  output logic tx_forward,
  output logic tx_insert_ip_sum,
  output logic tx_insert_payload_sum,
  output logic tx_wb_valid,
  output logic [31:0] tx_wb_word0,
  output logic tx_skip
);
  import edf_pkg::*;

  // Pin-level PHY status crosses domains: two flops first
  logic crs_m_r, crs_s_r, jab_m_r, jab_s_r;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      crs_m_r <= 1'b0;
      crs_s_r <= 1'b0;
      jab_m_r <= 1'b0;
      jab_s_r <= 1'b0;
    end else begin
      crs_m_r <= carrier_sense;
      crs_s_r <= crs_m_r;
      jab_m_r <= jabber_expired;
      jab_s_r <= jab_m_r;
    end
  end

  // Receive addressing
  wire chained = rx_desc_word1[`EDF_RX_CHAIN_BIT];
  wire end_ring = rx_desc_word1[`EDF_RX_END_RING_BIT];
  // Buffer 2 only exists in ring mode
  wire [31:0] sel_ptr = (rx_use_buf2 && !chained) ? rx_desc_word3 : rx_desc_word2;
  wire [31:0] ag_addr;
  wire [2:0] ag_shift;

  edf_addr_gen u_addr_gen (
    .buf_ptr(sel_ptr),
    .first_part(rx_first_part),
    .wr_addr(ag_addr),
    .byte_shift(ag_shift)
  );

  // End of ring wins over chaining: no next pointer taken then
  wire [31:0] next_ptr = {rx_desc_word3[31:`EDF_ALIGN_BITS], 3'h0};

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_wr_addr <= 32'h0;
      rx_byte_shift <= 3'h0;
      rx_next_desc <= 32'h0;
      rx_chain_mode <= 1'b0;
      rx_next_valid <= 1'b0;
    end else if (rx_desc_load) begin
      rx_wr_addr <= ag_addr;
      rx_byte_shift <= ag_shift;
      rx_chain_mode <= chained;
      rx_next_desc <= next_ptr;
      rx_next_valid <= chained && !end_ring;
    end else begin
      rx_next_valid <= 1'b0;
    end
  end

  // Transmit descriptor
  edf_tx_state_e st_r, st_nxt;
  logic [12:0] cnt1_r, cnt2_r;
  logic [31:0] ptr1_r, ptr2_r;
  logic hdr_fault_r, jabber_r, ff_r, pay_fail_r, nc_r, loc_r, lc_r, ec_r, ed_r, uf_r;
  logic carrier_seen_r;

  wire owned = tx_desc_word0[`EDF_TX_OWN_BIT];
  wire take = (st_r == EDF_TX_IDLE) && tx_desc_load;
  wire bufs_empty = (cnt1_r == 13'h0) && (cnt2_r == 13'h0);
  wire in_run = (st_r == EDF_TX_RUN);
  wire use_b1 = (cnt1_r != 13'h0);
  // Forward at once outside store-and-forward; in it, once whole frame stored or FIFO full
  wire fwd_nxt = in_run && (!tx_store_forward || tx_frame_done || tx_fifo_full);
  wire early_fwd = in_run && tx_store_forward && tx_fifo_full && !tx_sum_ready;
  wire finish = in_run && (tx_frame_done || bufs_empty || flush_cmd);
  wire err_sum = jabber_r | ff_r | loc_r | nc_r | lc_r | ec_r | ed_r | uf_r;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      EDF_TX_IDLE: if (take && owned) st_nxt = EDF_TX_RUN;
      EDF_TX_RUN: if (finish) st_nxt = EDF_TX_WB;
      EDF_TX_WB: st_nxt = EDF_TX_IDLE;
      default: st_nxt = EDF_TX_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= EDF_TX_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Two buffers, each with its own count and pointer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt1_r <= 13'h0;
      cnt2_r <= 13'h0;
      ptr1_r <= 32'h0;
      ptr2_r <= 32'h0;
    end else if (take && owned) begin
      cnt1_r <= tx_buf1_count;
      cnt2_r <= tx_buf2_count;
      ptr1_r <= tx_buf1_ptr;
      ptr2_r <= tx_buf2_ptr;
    end else if (in_run && tx_byte_taken) begin
      if (use_b1) begin
        cnt1_r <= cnt1_r - 13'h1;
        ptr1_r <= ptr1_r + 32'h1;
      end else if (cnt2_r != 13'h0) begin
        cnt2_r <= cnt2_r - 13'h1;
        ptr2_r <= ptr2_r + 32'h1;
      end
    end
  end

  // Sticky status, cleared at descriptor take; events in that cycle are dropped
  always_ff @(posedge core_clk) begin
    if (srst) begin
      {hdr_fault_r, jabber_r, ff_r, pay_fail_r, nc_r, loc_r, lc_r, ec_r, ed_r, uf_r} <= 10'h0;
      carrier_seen_r <= 1'b0;
    end else if (take) begin
      {hdr_fault_r, jabber_r, ff_r, pay_fail_r, nc_r, loc_r, lc_r, ec_r, ed_r, uf_r} <= 10'h0;
      carrier_seen_r <= 1'b0;
    end else if (in_run) begin
      hdr_fault_r <= hdr_fault_r | ip_header_fault;
      jabber_r <= jabber_r | jab_s_r;
      ff_r <= ff_r | flush_cmd;
      pay_fail_r <= pay_fail_r | tx_payload_short | early_fwd;
      loc_r <= loc_r | loss_of_carrier;
      lc_r <= lc_r | late_collision;
      ec_r <= ec_r | excess_collision;
      ed_r <= ed_r | excess_deferral;
      uf_r <= uf_r | underflow;
      carrier_seen_r <= carrier_seen_r | crs_s_r;
      if (finish) nc_r <= !(carrier_seen_r | crs_s_r);
    end
  end

  function automatic logic [31:0] pack_status(input logic [9:0] f, input logic e);
    logic [31:0] w;
    w = 32'h0;
    w[`EDF_TX_HDR_FAULT_BIT] = f[9];
    w[`EDF_TX_JABBER_BIT] = f[8];
    w[`EDF_TX_FF_BIT] = f[7];
    w[`EDF_TX_PAY_FAIL_BIT] = f[6];
    w[`EDF_TX_NC_BIT] = f[5];
    w[`EDF_TX_LOC_BIT] = f[4];
    w[`EDF_TX_LC_BIT] = f[3];
    w[`EDF_TX_EC_BIT] = f[2];
    w[`EDF_TX_ED_BIT] = f[1];
    w[`EDF_TX_UF_BIT] = f[0];
    w[`EDF_TX_ERR_SUM_BIT] = e;
    return w;
  endfunction

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_desc_busy <= 1'b0;
      tx_rd_addr <= 32'h0;
      tx_forward <= 1'b0;
      tx_insert_ip_sum <= 1'b0;
      tx_insert_payload_sum <= 1'b0;
      tx_wb_valid <= 1'b0;
      tx_wb_word0 <= 32'h0;
      tx_skip <= 1'b0;
    end else begin
      tx_desc_busy <= (st_nxt != EDF_TX_IDLE);
      tx_rd_addr <= use_b1 ? ptr1_r : ptr2_r;
      tx_forward <= fwd_nxt;
      tx_insert_ip_sum <= in_run && !hdr_fault_r && !ip_header_fault;
      tx_insert_payload_sum <= in_run && !pay_fail_r && !tx_payload_short && !early_fwd;
      tx_skip <= take && !owned;
      tx_wb_valid <= (st_r == EDF_TX_WB);
      // Owner bit written back clear hands descriptor to host
      if (st_r == EDF_TX_WB) begin
        tx_wb_word0 <= pack_status({hdr_fault_r, jabber_r, ff_r, pay_fail_r, nc_r, loc_r, lc_r,
                                    ec_r, ed_r, uf_r}, err_sum);
      end
    end
  end

  a_wb_own_clear: assert property (@(posedge core_clk) disable iff (srst)
    tx_wb_valid |-> !tx_wb_word0[`EDF_TX_OWN_BIT]) else $error("owner not cleared");
  a_err_sum_or: assert property (@(posedge core_clk) disable iff (srst)
    tx_wb_valid |-> (tx_wb_word0[`EDF_TX_ERR_SUM_BIT] == |(tx_wb_word0 &
      32'h00006f06))) else $error("error summary wrong");
  a_host_owned_skip: assert property (@(posedge core_clk) disable iff (srst)
    (take && !owned) |=> (tx_skip && !tx_desc_busy)) else $error("host desc used");
  a_hdr_no_sum: assert property (@(posedge core_clk) disable iff (srst)
    (in_run && ip_header_fault) |=> !tx_insert_ip_sum) else $error("sum inserted");
  a_rx_addr_align: assert property (@(posedge core_clk) disable iff (srst)
    rx_wr_addr[2:0] == 3'h0) else $error("rx addr unaligned");
  a_rx_mid_shift: assert property (@(posedge core_clk) disable iff (srst)
    (rx_desc_load && !rx_first_part) |=> rx_byte_shift == 3'h0)
    else $error("mid shift");
  a_rx_sof_shift: assert property (@(posedge core_clk) disable iff (srst)
    (rx_desc_load && rx_first_part && !rx_use_buf2) |=>
      rx_byte_shift == $past(rx_desc_word2[2:0])) else $error("sof shift");
  a_next_desc: assert property (@(posedge core_clk) disable iff (srst)
    rx_next_valid |-> (rx_chain_mode && rx_next_desc[2:0] == 3'h0))
    else $error("bad next desc");
  a_sf_full_fwd: assert property (@(posedge core_clk) disable iff (srst)
    (in_run && tx_store_forward && tx_fifo_full) |=> tx_forward)
    else $error("no forward on full");
  a_jabber_flag: assert property (@(posedge core_clk) disable iff (srst)
    (in_run && jab_s_r && !take) |=> jabber_r) else $error("jabber lost");
endmodule

// ### src/edf_consts.svh
// Constants for the ethernet DMA descriptor field handling block
`ifndef EDF_CONSTS_SVH
`define EDF_CONSTS_SVH
`define EDF_ALIGN_BITS 3
`define EDF_RX_CHAIN_BIT 24
`define EDF_RX_END_RING_BIT 25
`define EDF_TX_OWN_BIT 31
`define EDF_TX_HDR_FAULT_BIT 16
`define EDF_TX_ERR_SUM_BIT 15
`define EDF_TX_JABBER_BIT 14
`define EDF_TX_FF_BIT 13
`define EDF_TX_PAY_FAIL_BIT 12
`define EDF_TX_LOC_BIT 11
`define EDF_TX_NC_BIT 10
`define EDF_TX_LC_BIT 9
`define EDF_TX_EC_BIT 8
`define EDF_TX_ED_BIT 2
`define EDF_TX_UF_BIT 1
`define EDF_FIFO_DEPTH 2048
`endif

// ### src/edf_pkg.sv
// Types for the ethernet DMA descriptor field handling block
package edf_pkg;
  typedef logic [31:0] edf_word_t;
  typedef enum logic [1:0] {EDF_TX_IDLE, EDF_TX_RUN, EDF_TX_WB} edf_tx_state_e;
endpackage

// ### src/edf_addr_gen.sv
// Receive buffer address generator: aligned write address and byte shift
`timescale 1ns/1ps
`include "edf_consts.svh"
module edf_addr_gen (
  input wire logic [31:0] buf_ptr,
  input wire logic first_part,
  output logic [31:0] wr_addr,
  output logic [2:0] byte_shift
);
  // Start of frame: aligned write, data shifted by pointer low bits
  assign wr_addr = {buf_ptr[31:`EDF_ALIGN_BITS], 3'h0};
  assign byte_shift = first_part ? buf_ptr[2:0] : 3'h0;
endmodule

// ### dv/edf_host_model.sv
// Host-side descriptor memory model feeding descriptor words
`timescale 1ns/1ps
module edf_host_model (
  input wire logic [1:0] sel,
  output edf_pkg::edf_word_t w1,
  output edf_pkg::edf_word_t w2,
  output edf_pkg::edf_word_t w3,
  output edf_pkg::edf_word_t t0
);
  import edf_pkg::*;
  always_comb begin
    w2 = 32'h1000_0005;
    w1 = 32'h0000_0000;
    w3 = 32'h3000_0003;
    t0 = 32'h8000_0000;
    if (sel == 2'h1) begin
      w1 = 32'h0100_0000;
      w3 = 32'h2000_0000;
      t0 = 32'h0000_0000;
    end
    // Chained and end of ring together: no next descriptor follows
    if (sel == 2'h3) begin
      w1 = 32'h0300_0000;
      w3 = 32'h2000_0000;
    end
  end
endmodule

// ### dv/tb_top.sv
// Self-checking bench for the descriptor field block
`timescale 1ns/1ps
module tb_top;
  import edf_pkg::*;
  logic core_clk = 0, srst = 1, rx_desc_load = 0, rx_use_buf2 = 0, rx_first_part = 0;
  logic tx_desc_load = 0, tx_byte_taken = 0, tx_frame_done = 0, tx_store_forward = 0;
  logic tx_fifo_full = 0, tx_sum_ready = 0, tx_payload_short = 0, ip_header_fault = 0;
  logic jabber_expired = 0, flush_cmd = 0, carrier_sense = 0;
  logic [4:0] errs = 5'h00;
  logic [12:0] c1 = 13'h100, c2 = 13'h100;
  logic [1:0] sel = 2'h0;
  edf_word_t w1, w2, w3, t0;
  logic [31:0] rx_wr_addr, rx_next_desc, tx_rd_addr, tx_wb_word0;
  logic [2:0] rx_byte_shift;
  logic rx_chain_mode, rx_next_valid, tx_desc_busy, tx_forward, tx_insert_ip_sum;
  logic tx_insert_payload_sum, tx_wb_valid, tx_skip;
  int err_count = 0, num_checks = 0;
  edf_host_model host (.sel(sel), .w1(w1), .w2(w2), .w3(w3), .t0(t0));
  edf_desc_top dut (.core_clk(core_clk), .srst(srst), .rx_desc_load(rx_desc_load),
    .rx_desc_word1(w1), .rx_desc_word2(w2), .rx_desc_word3(w3), .rx_use_buf2(rx_use_buf2),
    .rx_first_part(rx_first_part), .rx_wr_addr(rx_wr_addr), .rx_byte_shift(rx_byte_shift),
    .rx_next_desc(rx_next_desc), .rx_chain_mode(rx_chain_mode), .rx_next_valid(rx_next_valid),
    .tx_desc_load(tx_desc_load), .tx_desc_word0(t0), .tx_buf1_count(c1), .tx_buf2_count(c2),
    .tx_buf1_ptr(32'h4000_0000), .tx_buf2_ptr(32'h5000_0008), .tx_byte_taken(tx_byte_taken),
    .tx_frame_done(tx_frame_done), .tx_store_forward(tx_store_forward),
    .tx_fifo_full(tx_fifo_full), .tx_sum_ready(tx_sum_ready),
    .tx_payload_short(tx_payload_short), .ip_header_fault(ip_header_fault),
    .jabber_expired(jabber_expired), .flush_cmd(flush_cmd), .carrier_sense(carrier_sense),
    .loss_of_carrier(errs[4]), .late_collision(errs[3]), .excess_collision(errs[2]),
    .excess_deferral(errs[1]), .underflow(errs[0]), .tx_desc_busy(tx_desc_busy),
    .tx_rd_addr(tx_rd_addr), .tx_forward(tx_forward), .tx_insert_ip_sum(tx_insert_ip_sum),
    .tx_insert_payload_sum(tx_insert_payload_sum), .tx_wb_valid(tx_wb_valid),
    .tx_wb_word0(tx_wb_word0), .tx_skip(tx_skip));
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic rx_ld(input logic [1:0] s, input logic b2, input logic f);
    @(posedge core_clk);
    sel <= s;
    rx_use_buf2 <= b2;
    rx_first_part <= f;
    rx_desc_load <= 1;
    @(posedge core_clk);
    rx_desc_load <= 0;
    #1;
  endtask
  task automatic tx_go(input logic [1:0] s);
    @(posedge core_clk);
    sel <= s;
    tx_desc_load <= 1;
    @(posedge core_clk);
    tx_desc_load <= 0;
    #1;
  endtask
  task automatic pulse_done();
    @(posedge core_clk);
    tx_frame_done <= 1;
    @(posedge core_clk);
    tx_frame_done <= 0;
  endtask
  task automatic wait_wb(input logic [31:0] exp);
    for (int i = 0; i < 40 && tx_wb_valid !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(32'(tx_wb_valid), 32'h1);
    chk(tx_wb_word0, exp);
  endtask
  task automatic t_rx();
    rx_ld(2'h0, 0, 1);
    chk(rx_wr_addr, 32'h1000_0000);
    chk(32'(rx_byte_shift), 32'h5);
    chk(32'(rx_chain_mode), 32'h0);
    rx_ld(2'h0, 0, 0);
    chk(32'(rx_byte_shift), 32'h0);
    rx_ld(2'h0, 1, 1);
    chk(rx_wr_addr, 32'h3000_0000);
    chk(32'(rx_byte_shift), 32'h3);
    rx_ld(2'h0, 1, 0);
    chk(32'(rx_byte_shift), 32'h0);
    rx_ld(2'h1, 0, 1);
    chk(32'(rx_chain_mode), 32'h1);
    chk(rx_next_desc, 32'h2000_0000);
    chk(32'(rx_next_valid), 32'h1);
    @(posedge core_clk);
    #1;
    chk(32'(rx_next_valid), 32'h0);
    rx_ld(2'h3, 1, 1);
    chk(rx_wr_addr, 32'h1000_0000);
    chk(32'(rx_chain_mode), 32'h1);
    chk(32'(rx_next_valid), 32'h0);
    $display("test rx done");
  endtask
  task automatic t_tx_err();
    tx_go(2'h2);
    chk(32'(tx_desc_busy), 32'h1);
    @(posedge core_clk);
    errs <= 5'h1f;
    jabber_expired <= 1;
    ip_header_fault <= 1;
    repeat (4) @(posedge core_clk);
    #1;
    chk(32'(tx_insert_ip_sum), 32'h0);
    pulse_done();
    wait_wb(32'h0001_cf06);
    @(posedge core_clk);
    errs <= 5'h00;
    jabber_expired <= 0;
    ip_header_fault <= 0;
    carrier_sense <= 1;
    tx_go(2'h1);
    chk(32'(tx_skip), 32'h1);
    chk(32'(tx_desc_busy), 32'h0);
    $display("test tx errors done");
  endtask
  task automatic t_flush_sf();
    tx_go(2'h2);
    repeat (3) @(posedge core_clk);
    flush_cmd <= 1;
    @(posedge core_clk);
    flush_cmd <= 0;
    wait_wb(32'h0000_a000);
    @(posedge core_clk);
    tx_store_forward <= 1;
    tx_go(2'h2);
    repeat (2) @(posedge core_clk);
    #1;
    chk(32'(tx_forward), 32'h0);
    @(posedge core_clk);
    tx_fifo_full <= 1;
    repeat (3) @(posedge core_clk);
    #1;
    chk(32'(tx_forward), 32'h1);
    chk(32'(tx_insert_payload_sum), 32'h0);
    pulse_done();
    wait_wb(32'h0000_1000);
    @(posedge core_clk);
    tx_fifo_full <= 0;
    tx_store_forward <= 0;
    $display("test flush and store-forward done");
  endtask
  task automatic t_bytes();
    c1 <= 13'h001;
    c2 <= 13'h001;
    tx_go(2'h2);
    chk(tx_rd_addr, 32'h4000_0000);
    @(posedge core_clk);
    tx_byte_taken <= 1;
    @(posedge core_clk);
    tx_byte_taken <= 0;
    repeat (2) @(posedge core_clk);
    #1;
    chk(tx_rd_addr, 32'h5000_0008);
    chk(32'(tx_insert_ip_sum), 32'h1);
    chk(32'(tx_insert_payload_sum), 32'h1);
    @(posedge core_clk);
    tx_byte_taken <= 1;
    @(posedge core_clk);
    tx_byte_taken <= 0;
    wait_wb(32'h0000_0000);
    $display("test buffer drain done");
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    srst <= 0;
    t_rx();
    t_tx_err();
    t_flush_sf();
    t_bytes();
    end_of_test();
  end
  // Whole run needs under a hundred cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    end_of_test();
  end
endmodule
